/* hdl/boot_strap_mode_select.sv */
// Boot strap sampling and boot mode selection
//
// Summary of operation
// (RULE_01) Sample the three strap pins at power-up; pattern picks boot flow.
// (RULE_02) Latch straps into a register before reset release; it drives decisions. Code latches them after release, once the settle count runs out.
// (RULE_03) Latched code sets boot flow and default debug/serial pin mapping.
// (RULE_04) Code 100 selects serial load over the serial port.
// (RULE_05) Serial load waits forever for code, no timeout.
// (RULE_06) Board changes straps before next power-up to leave serial load.
// (RULE_07) Serial load also maps debug as four-wire JTAG.
// (RULE_08) Code 001 runs functional with two-pin SWD.
// (RULE_09) Code 000 runs functional with four-pin JTAG.
// (RULE_10) Code 010 checks receive line for break, keeps four-wire JTAG.
// (RULE_11) Break seen gives serial load, otherwise functional run.
// (RULE_12) Code 011 starts factory restore after reset toggles.
// (RULE_13) After sensing, strap bit 2 pin may be reused.
// (RULE_14) Board uses reused bit 2 pin only as a device output. Board model drives it into the device when reuse_en is set.
// (RULE_15) Strap bit 0 and 1 pins stay dedicated after boot.
// (RULE_16) Outside party holds restore pattern and raises the reset pin.
// (RULE_17) Unfinished factory restore resumes on next power-up.
// (RULE_18) Unassigned codes decode as reserved and are flagged.
// (RULE_19) Latched straps hold until next power-up despite bit 2 pin reuse.
`timescale 1ns/10ps

module boot_strap_mode_select
  import boot_strap_pkg::*;
#(
  parameter int BREAK_CNT = BREAK_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       boot_strap_bit2,
  input  wire logic       boot_strap_bit1,
  input  wire logic       boot_strap_bit0,
  input  wire logic       uart_rx,
  input  wire logic       code_loaded,
  input  wire logic       restore_pending,
  input  wire logic       restore_done,
  output boot_select_type boot_select,
  output logic [2:0]      latched_strap,
  output logic            sensing_done,
  output logic            restore_mark
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    boot_state_type  state;
    logic [2:0]      strap;
    logic            captured;
    logic [15:0]     count;
    logic            resume;
    logic            restore_mark;
    boot_select_type sel;
  } strap_state_type;

  localparam logic [15:0] BREAK_LIMIT  = 16'(BREAK_CNT);
  localparam logic [15:0] SETTLE_LIMIT = 16'(SETTLE_CYCLES);

  strap_state_type cur;
  strap_state_type next_cur;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Straps are caught by a clocked process after release; async reset takes constants
  always_comb begin
    next_cur = cur;
    case (cur.state)
      BOOT_SENSE: begin
        // The restore flag is read once, on the first edge after release
        if (cur.count == 16'h0000) begin
          next_cur.resume = restore_pending;                                  // [RULE_17]
        end
        // Hold sampling for a few cycles so pull resistors settle
        if (cur.count == SETTLE_LIMIT) begin
          next_cur.strap    = {boot_strap_bit2, boot_strap_bit1, boot_strap_bit0}; // [RULE_01]
          next_cur.captured = 1'b1;                                                 // [RULE_02]
          next_cur.count    = 16'h0000;
          next_cur.state    = BOOT_DECIDE;
        end else begin
          next_cur.count = cur.count + 16'h0001;
        end
      end
      BOOT_DECIDE: begin
        // A pending restore wins over the straps so power loss cannot skip it
        next_cur.sel.bit2_pin_free = 1'b1;                                    // [RULE_13]
        if (cur.resume) begin
          next_cur.state               = BOOT_RESTORE;                        // [RULE_17]
          next_cur.sel.factory_restore = 1'b1;
          next_cur.restore_mark        = 1'b1;
          next_cur.sel.debug_map       = DEBUG_JTAG;
        end else begin
          case (cur.strap)                                                    // [RULE_03]
            SERIAL_LOAD_CODE: begin
              next_cur.state              = BOOT_LOAD;                        // [RULE_04]
              next_cur.sel.serial_load    = 1'b1;
              next_cur.sel.serial_port_en = 1'b1;
              next_cur.sel.debug_map      = DEBUG_JTAG;                       // [RULE_07]
            end
            RUN_TWO_WIRE_CODE: begin
              next_cur.state              = BOOT_RUN;
              next_cur.sel.functional_run = 1'b1;
              next_cur.sel.debug_map      = DEBUG_SWD;                        // [RULE_08]
            end
            RUN_FOUR_WIRE_CODE: begin
              next_cur.state              = BOOT_RUN;
              next_cur.sel.functional_run = 1'b1;
              next_cur.sel.debug_map      = DEBUG_JTAG;                       // [RULE_09]
            end
            BREAK_DETECT_CODE: begin
              next_cur.state              = BOOT_BREAK;
              next_cur.sel.serial_port_en = 1'b1;
              next_cur.sel.debug_map      = DEBUG_JTAG;                       // [RULE_10]
            end
            FACTORY_RESTORE_CODE: begin
              next_cur.state               = BOOT_RESTORE;                    // [RULE_12]
              next_cur.sel.factory_restore = 1'b1;
              next_cur.restore_mark        = 1'b1;
              next_cur.sel.debug_map       = DEBUG_JTAG;
            end
            default: begin
              next_cur.state             = BOOT_HALT;
              next_cur.sel.reserved_code = 1'b1;                              // [RULE_18]
            end
          endcase
        end
      end
      BOOT_BREAK: begin
        // Break is a receive line held low for the break window
        if (uart_rx) begin
          next_cur.state              = BOOT_RUN;                             // [RULE_11]
          next_cur.sel.functional_run = 1'b1;
          next_cur.sel.serial_port_en = 1'b0;
        end else if (cur.count == BREAK_LIMIT - 16'h0001) begin
          next_cur.state           = BOOT_LOAD;                               // [RULE_11]
          next_cur.sel.serial_load = 1'b1;
        end else begin
          next_cur.count = cur.count + 16'h0001;
        end
      end
      BOOT_LOAD: begin
        // No timeout: only a new power-up with other straps leaves here
        if (code_loaded) begin
          next_cur.state = BOOT_LOAD;                                         // [RULE_05]
        end
      end
      BOOT_RESTORE: begin
        if (restore_done) begin
          next_cur.restore_mark = 1'b0;
          next_cur.state        = BOOT_RUN;
          next_cur.sel.factory_restore = 1'b0;
          next_cur.sel.functional_run  = 1'b1;
        end
      end
      BOOT_RUN: next_cur.state = BOOT_RUN;
      BOOT_HALT: next_cur.state = BOOT_HALT;
      default: next_cur.state = BOOT_HALT;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // The strap field is written only in BOOT_SENSE, so bit 2 pin reuse can't disturb it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cur          <= '0;
      cur.strap    <= STRAP_RESET_VALUE;
      cur.sel      <= '0;
    end else begin
      cur          <= next_cur;                                               // [RULE_19]
    end
  end

  // Outputs come straight from the state record; bit 0/1 pins never go free
  assign boot_select   = cur.sel;                                             // [RULE_15]
  assign latched_strap = cur.strap;
  assign sensing_done  = cur.captured;
  assign restore_mark  = cur.restore_mark;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_strap_hold;
    @(posedge mclk) disable iff (!nrst)
      cur.captured |=> $stable(cur.strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // [RULE_19]
    else $error("strap changed after capture");

  property p_serial_load;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && !cur.resume && cur.strap == SERIAL_LOAD_CODE)
        |=> (boot_select.serial_load && boot_select.debug_map == DEBUG_JTAG);
  endproperty
  a_serial_load: assert property (p_serial_load) // [RULE_04]
    else $error("serial load not selected");

  property p_two_wire;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && !cur.resume && cur.strap == RUN_TWO_WIRE_CODE)
        |=> (boot_select.debug_map == DEBUG_SWD && boot_select.functional_run);
  endproperty
  a_two_wire: assert property (p_two_wire) // [RULE_08]
    else $error("two-wire run not selected");

  property p_four_wire;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && !cur.resume && cur.strap == RUN_FOUR_WIRE_CODE)
        |=> (boot_select.debug_map == DEBUG_JTAG && boot_select.functional_run);
  endproperty
  a_four_wire: assert property (p_four_wire) // [RULE_09]
    else $error("four-wire run not selected");

  property p_break_run;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_BREAK && uart_rx) |=> (cur.state == BOOT_RUN);
  endproperty
  a_break_run: assert property (p_break_run) // [RULE_11]
    else $error("idle line did not run");

  property p_load_stays;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_LOAD) |=> (cur.state == BOOT_LOAD);
  endproperty
  a_load_stays: assert property (p_load_stays) // [RULE_05]
    else $error("serial load left");

  property p_reserved;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && !cur.resume && cur.strap inside {3'h5, 3'h6, 3'h7})
        |=> boot_select.reserved_code;
  endproperty
  a_reserved: assert property (p_reserved) // [RULE_18]
    else $error("reserved code not flagged");

  property p_resume;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && cur.resume) |=> (restore_mark && boot_select.factory_restore);
  endproperty
  a_resume: assert property (p_resume) // [RULE_17]
    else $error("restore not resumed");

  property p_capture_time;
    @(posedge mclk) disable iff (!nrst)
      $rose(sensing_done) |-> $past(cur.state) == BOOT_SENSE;
  endproperty
  a_capture_time: assert property (p_capture_time) // [RULE_02]
    else $error("capture out of sense");

  // Capture happens exactly when the settle count runs out
  property p_capture_edge;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_SENSE && cur.count == SETTLE_LIMIT) |=> sensing_done;
  endproperty
  a_capture_edge: assert property (p_capture_edge) // [RULE_01]
    else $error("straps not captured");

  // Nothing is offered to the device before the straps are in
  property p_sense_quiet;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_SENSE) |-> (!sensing_done && boot_select == '0);
  endproperty
  a_sense_quiet: assert property (p_sense_quiet) // [RULE_02]
    else $error("outputs active while sensing");

  // Bit 2 pin is only handed over once sensing is over
  property p_pin_free;
    @(posedge mclk) disable iff (!nrst)
      boot_select.bit2_pin_free |-> sensing_done;
  endproperty
  a_pin_free: assert property (p_pin_free) // [RULE_13]
    else $error("bit 2 pin freed early");

  // At most one boot flow is active at a time
  property p_one_flow;
    @(posedge mclk) disable iff (!nrst)
      $onehot0({boot_select.serial_load, boot_select.functional_run,
                boot_select.factory_restore, boot_select.reserved_code});
  endproperty
  a_one_flow: assert property (p_one_flow) // [RULE_03]
    else $error("two boot flows at once");

  property p_break_sel;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && !cur.resume && cur.strap == BREAK_DETECT_CODE)
        |=> (cur.state == BOOT_BREAK && boot_select.debug_map == DEBUG_JTAG);
  endproperty
  a_break_sel: assert property (p_break_sel) // [RULE_10]
    else $error("break detect not entered");

  // A full break window of low samples means a loader is attached
  property p_break_load;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_BREAK && !uart_rx && cur.count == BREAK_LIMIT - 16'h0001)
        |=> (cur.state == BOOT_LOAD && boot_select.serial_load);
  endproperty
  a_break_load: assert property (p_break_load) // [RULE_11]
    else $error("break did not load");

  // The loader needs the serial port and four-wire debug the whole time
  property p_load_port;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_LOAD) |-> (boot_select.serial_port_en && boot_select.debug_map == DEBUG_JTAG);
  endproperty
  a_load_port: assert property (p_load_port) // [RULE_07]
    else $error("load without port or JTAG");

  property p_restore_code;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_DECIDE && !cur.resume && cur.strap == FACTORY_RESTORE_CODE)
        |=> (restore_mark && boot_select.factory_restore);
  endproperty
  a_restore_code: assert property (p_restore_code) // [RULE_12]
    else $error("restore not started");

  // The mark drops only when the restore has finished
  property p_restore_end;
    @(posedge mclk) disable iff (!nrst)
      (cur.state == BOOT_RESTORE && restore_done)
        |=> (boot_select.functional_run && !restore_mark && !boot_select.factory_restore);
  endproperty
  a_restore_end: assert property (p_restore_end) // [RULE_17]
    else $error("restore did not end cleanly");

  // Main boot flows reached
  c_load:    cover property (@(posedge mclk) disable iff (!nrst) cur.state == BOOT_LOAD);
  c_run:     cover property (@(posedge mclk) disable iff (!nrst) cur.state == BOOT_RUN);
  c_restore: cover property (@(posedge mclk) disable iff (!nrst) cur.state == BOOT_RESTORE);
  c_halt:    cover property (@(posedge mclk) disable iff (!nrst) cur.state == BOOT_HALT);
  c_break:   cover property (@(posedge mclk) disable iff (!nrst) cur.state == BOOT_BREAK);

endmodule

/* hdl/boot_strap_pkg.sv */
// Package of constants and types for the boot strap mode selector
package boot_strap_pkg;

  // ----------------------------------------------------------------------
  // Strap codes, ordered {bit2, bit1, bit0}
  // ----------------------------------------------------------------------
  localparam logic [2:0] SERIAL_LOAD_CODE     = 3'h4;
  localparam logic [2:0] RUN_TWO_WIRE_CODE    = 3'h1;
  localparam logic [2:0] RUN_FOUR_WIRE_CODE   = 3'h0;
  localparam logic [2:0] BREAK_DETECT_CODE    = 3'h2;
  localparam logic [2:0] FACTORY_RESTORE_CODE = 3'h3;

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         BREAK_TIME_NS     = 1000;
  localparam int         BREAK_CYCLES      = (BREAK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         SETTLE_CYCLES     = 4;
  localparam logic [2:0] STRAP_RESET_VALUE = 3'h0;

  // Sequencer states: sensing, deciding, then the selected boot flow
  typedef enum logic [2:0] {
    BOOT_SENSE   = 3'h0,
    BOOT_DECIDE  = 3'h1,
    BOOT_BREAK   = 3'h3,
    BOOT_LOAD    = 3'h2,
    BOOT_RUN     = 3'h6,
    BOOT_RESTORE = 3'h7,
    BOOT_HALT    = 3'h5
  } boot_state_type;

  // Debug pin mapping
  typedef enum logic [1:0] {
    DEBUG_NONE = 2'h0,
    DEBUG_SWD  = 2'h1,
    DEBUG_JTAG = 2'h2
  } debug_map_type;

  // Outputs that travel together toward the rest of the device
  typedef struct packed {
    logic          serial_load;
    logic          functional_run;
    logic          factory_restore;
    logic          reserved_code;
    logic          serial_port_en;
    logic          bit2_pin_free;
    debug_map_type debug_map;
  } boot_select_type;

endpackage

/* tb/board_strap_model.sv */
// Board strap resistors and serial loader facing the boot mode selector
`timescale 1ns/10ps

module board_strap_model (
  input  wire logic [2:0] strap_code,
  input  wire logic       send_break,
  input  wire logic       reuse_en,
  input  wire logic       reuse_val,
  output logic            boot_strap_bit2,
  output logic            boot_strap_bit1,
  output logic            boot_strap_bit0,
  output logic            uart_rx
);
  // ----------------------------------------------------------------------
  // Strap levels
  // ----------------------------------------------------------------------
  // Straps are plain resistor levels, so no clock is needed here
  assign boot_strap_bit2 = reuse_en ? reuse_val : strap_code[2];
  assign boot_strap_bit1 = strap_code[1];
  assign boot_strap_bit0 = strap_code[0];
  // Loader holds the line low for a break, otherwise it idles high
  assign uart_rx         = ~send_break;
endmodule

/* tb/testbench.sv */
// Self-checking bench for the boot strap mode selector
`timescale 1ns/10ps

module testbench
  import boot_strap_pkg::*;
;
  localparam int BRK = 4;
  logic            mclk = 1'b0;
  logic            nrst = 1'b0;
  logic [2:0]      strap_code = 3'h0;
  logic            send_break = 1'b0;
  logic            reuse_en = 1'b0;
  logic            reuse_val = 1'b0;
  logic            code_loaded = 1'b0;
  logic            restore_pending = 1'b0;
  logic            restore_done = 1'b0;
  logic            bit2, bit1, bit0, rx;
  boot_select_type boot_select;
  logic [2:0]      latched_strap;
  logic            sensing_done, restore_mark;
  int              n_fail = 0;
  int              tests_run = 0;
  int              cycles = 0;

  board_strap_model i_board (.strap_code(strap_code), .send_break(send_break),
    .reuse_en(reuse_en), .reuse_val(reuse_val), .boot_strap_bit2(bit2),
    .boot_strap_bit1(bit1), .boot_strap_bit0(bit0), .uart_rx(rx));

  boot_strap_mode_select #(.BREAK_CNT(BRK)) i_dut (.mclk(mclk), .nrst(nrst),
    .boot_strap_bit2(bit2), .boot_strap_bit1(bit1), .boot_strap_bit0(bit0),
    .uart_rx(rx), .code_loaded(code_loaded), .restore_pending(restore_pending),
    .restore_done(restore_done), .boot_select(boot_select),
    .latched_strap(latched_strap), .sensing_done(sensing_done),
    .restore_mark(restore_mark));

  // ----------------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------------
  initial begin
    forever #5 mclk = ~mclk;
  end

  // Cuts a hang short; the whole run needs well under this
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Power-up with a given strap pattern, stops one edge after capture
  // ----------------------------------------------------------------------
  task automatic do_boot(input logic [2:0] code, input logic brk, input logic pend);
    int n;
    n = 0;
    @(posedge mclk);
    #1 nrst = 1'b0;
    strap_code = code;
    send_break = brk;
    restore_pending = pend;
    reuse_en = 1'b0;
    repeat (3) @(posedge mclk);
    #1 check({7'h00, sensing_done}, 8'h00, "sensing in reset");
    check(boot_select, 8'h00, "select in reset");
    check({5'h00, latched_strap}, {5'h00, STRAP_RESET_VALUE}, "strap in reset");
    nrst = 1'b1;
    while (sensing_done !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    check({5'h00, latched_strap}, {5'h00, code}, "latched code");
    @(posedge mclk);
    #1 check({7'h00, boot_select.bit2_pin_free}, 8'h01, "bit2 free");
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Every direct code and every unassigned code, one power-up each
  task automatic t_table();
    logic [2:0]    codes [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    debug_map_type dbg [3] = '{DEBUG_JTAG, DEBUG_SWD, DEBUG_JTAG};
    for (int i = 0; i < 6; i++) begin
      do_boot(codes[i], 1'b0, 1'b0);
      check({7'h00, boot_select.functional_run}, {7'h00, i < 2}, "run");
      check({7'h00, boot_select.serial_load}, {7'h00, i == 2}, "load");
      check({7'h00, boot_select.reserved_code}, {7'h00, i > 2}, "reserved");
      check({7'h00, boot_select.serial_port_en}, {7'h00, i == 2}, "port");
      check({7'h00, boot_select.factory_restore}, 8'h00, "no restore");
      if (i < 3) begin
        check({6'h00, boot_select.debug_map}, {6'h00, dbg[i]}, "debug");
      end
    end
  endtask

  // Serial load never gives up, even long after code arrived
  task automatic t_serial_wait();
    do_boot(3'h4, 1'b0, 1'b0);
    code_loaded = 1'b1;
    repeat (300) @(posedge mclk);
    #1 check({7'h00, boot_select.serial_load}, 8'h01, "load holds");
    code_loaded = 1'b0;
  endtask

  // Break-detect code with idle line, then with a held break
  task automatic t_break();
    do_boot(3'h2, 1'b0, 1'b0);
    repeat (2) @(posedge mclk);
    #1 check({7'h00, boot_select.functional_run}, 8'h01, "no break run");
    check({6'h00, boot_select.debug_map}, {6'h00, DEBUG_JTAG}, "debug");
    check({7'h00, boot_select.serial_port_en}, 8'h00, "run port off");
    do_boot(3'h2, 1'b1, 1'b0);
    repeat (BRK + 6) @(posedge mclk);
    #1 check({7'h00, boot_select.serial_load}, 8'h01, "break load");
    check({7'h00, boot_select.functional_run}, 8'h00, "break no run");
    check({7'h00, boot_select.serial_port_en}, 8'h01, "load port on");
  endtask

  // Restore runs until done, then the device goes on to run
  task automatic finish_restore();
    check({7'h00, boot_select.factory_restore}, 8'h01, "restore");
    check({7'h00, restore_mark}, 8'h01, "mark set");
    restore_done = 1'b1;
    @(posedge mclk);
    #1 restore_done = 1'b0;
    restore_pending = 1'b0;
    repeat (2) @(posedge mclk);
    #1 check({7'h00, restore_mark}, 8'h00, "mark clear");
    check({7'h00, boot_select.functional_run}, 8'h01, "after restore");
  endtask

  task automatic t_restore();
    do_boot(3'h3, 1'b0, 1'b0);
    finish_restore();
    do_boot(3'h0, 1'b0, 1'b1);
    finish_restore();
  endtask

  // Reused bit 2 pin toggles after capture; the latched code stays
  task automatic t_hold();
    do_boot(3'h0, 1'b0, 1'b0);
    reuse_en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      reuse_val = ~reuse_val;
      @(posedge mclk);
      #1;
    end
    check({5'h00, latched_strap}, 8'h00, "latched holds");
    check({7'h00, boot_select.functional_run}, 8'h01, "run holds");
  endtask

  initial begin
    t_table();
    t_serial_wait();
    t_break();
    t_restore();
    t_hold();
    final_report();
  end
endmodule
